// file: src/slcc_defs.svh
// Constants for the synthesizer loop and calibration configuration bank.
// Assumes a 50 MHz always-on clock and a 32-bit classic Wishbone port.
// Function
// R1: Narrow-bandwidth bit of A at one drives A into 200 Hz jitter-cleaner bandwidth.
// R2: Narrow-bandwidth bit of A resets to zero, giving normal clock-generator bandwidth.
// R3: Software pairs A's bandwidth choice with matching detector, pump and filter.
// R4: Stretch bit of B at zero, its reset value, selects 200 ps pulse width.
// R5: Stretch bit of B at one selects roughly 600 ps pulse width.
// R6: Loop-filter order select of B resets to 0x3, second-order filter.
// R7: Loop-filter order code 0x7 selects the third-order filter for B.
// R8: Software never writes the reserved filter order codes 0x0-0x2, 0x4-0x6.
// R9: Closed-loop wait code of B, reset 0, picks 30us/300us/30ms/300ms.
// R10: Software uses closed-loop code 0x1 for bandwidth above 10 kHz.
// R11: Software picks a longer closed-loop code below 1 kHz bandwidth.
// R12: Jitter-cleaner operation should use closed-loop code 0x3, the longest wait.
// R13: VCO wait code of B, reset 0x1, picks 20us/400us/8ms/200ms.
// R14: Closed-loop wait is counted in cycles of the always-on clock.
// R15: Reserved bits read zero and ignore writes.
// R16: Each wait is a down-counter loaded on phase entry, ending at zero.
`ifndef SLCC_DEFS_SVH
`define SLCC_DEFS_SVH

`define SLCC_ADR_W       12
`define SLCC_IDX_W       10
`define SLCC_ADR_LSB     2
`define SLCC_DAT_W       32
`define SLCC_REG_W       8

// Register indices; byte address is four times the index
`define SLCC_IDX_A_CAL1  10'h078
`define SLCC_IDX_B_CTL2  10'h083
`define SLCC_IDX_B_CTL3  10'h084
`define SLCC_IDX_B_CAL0  10'h085
`define SLCC_IDX_CAL_CMD 10'h086
`define SLCC_IDX_CAL_STS 10'h087

`define SLCC_NBW_BIT     0
`define SLCC_STR_BIT     7
`define SLCC_FLT_MSB     2
`define SLCC_FLT_LSB     0
`define SLCC_CLW_MSB     3
`define SLCC_CLW_LSB     2
`define SLCC_VCW_MSB     1
`define SLCC_VCW_LSB     0
`define SLCC_START_BIT   0
`define SLCC_BUSY_BIT    0
`define SLCC_VPH_BIT     1
`define SLCC_CPH_BIT     2
`define SLCC_DONE_BIT    3

`define SLCC_RST_NBW     1'h0
`define SLCC_RST_STR     1'h0
`define SLCC_RST_FLT     3'h3
`define SLCC_FLT_THIRD   3'h7
`define SLCC_RST_CLW     2'h0
`define SLCC_RST_VCW     2'h1

`define SLCC_CLK_MHZ     50
`define SLCC_US_PER_MS   1000
`define SLCC_CNT_W       24

`define SLCC_VCO_T0_US   20
`define SLCC_VCO_T1_US   400
`define SLCC_VCO_T2_MS   8
`define SLCC_VCO_T3_MS   200
`define SLCC_CL_T0_US    30
`define SLCC_CL_T1_US    300
`define SLCC_CL_T2_MS    30
`define SLCC_CL_T3_MS    300

`define SLCC_VCO_C0 (`SLCC_VCO_T0_US * `SLCC_CLK_MHZ)
`define SLCC_VCO_C1 (`SLCC_VCO_T1_US * `SLCC_CLK_MHZ)
`define SLCC_VCO_C2 (`SLCC_VCO_T2_MS * `SLCC_US_PER_MS * `SLCC_CLK_MHZ)
`define SLCC_VCO_C3 (`SLCC_VCO_T3_MS * `SLCC_US_PER_MS * `SLCC_CLK_MHZ)
`define SLCC_CL_C0  (`SLCC_CL_T0_US * `SLCC_CLK_MHZ)
`define SLCC_CL_C1  (`SLCC_CL_T1_US * `SLCC_CLK_MHZ)
`define SLCC_CL_C2  (`SLCC_CL_T2_MS * `SLCC_US_PER_MS * `SLCC_CLK_MHZ)
`define SLCC_CL_C3  (`SLCC_CL_T3_MS * `SLCC_US_PER_MS * `SLCC_CLK_MHZ)

`endif

// file: src/slcc_pkg.sv
// Types shared by the configuration bank and its settle timer.
// Assumes slcc_defs.svh is on the include path.
`include "slcc_defs.svh"

package slcc_pkg;

    typedef struct packed {
        logic       narrow_bw_select_a;
        logic       pfd_pulse_stretch_b;
        logic [2:0] loop_filter_order_sel_b;
        logic [1:0] closed_loop_settle_sel_b;
        logic [1:0] vco_settle_sel_b;
    } slcc_cfg_t;

    typedef enum logic [1:0] {
        SLCC_IDLE,
        SLCC_VCO_SETTLE,
        SLCC_CL_SETTLE
    } slcc_state_t;

    typedef logic [`SLCC_CNT_W-1:0] slcc_cnt_t;

endpackage : slcc_pkg

// file: src/slcc_settle_timer.sv
// Down-counter that times one settling phase.
// Assumes the owner pulses load on phase entry and watches zero.
`timescale 1ns/100ps

module slcc_settle_timer (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               load_i,
    input  wire slcc_pkg::slcc_cnt_t load_val_i,
    output slcc_pkg::slcc_cnt_t     count_o,
    output logic                    zero_o
);

    slcc_pkg::slcc_cnt_t cnt;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (load_i) begin
            cnt <= load_val_i; // R16
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1; // R14
        end
    end

    assign count_o = cnt;
    assign zero_o  = (cnt == '0); // R16

endmodule : slcc_settle_timer

// file: src/slcc_regs.sv
// Configuration bank for synthesizers A and B with B's settle sequencer.
// Assumes a classic Wishbone master and the always-on system clock.
`timescale 1ns/100ps
`include "slcc_defs.svh"

module slcc_regs #(
    parameter slcc_pkg::slcc_cnt_t VCO_CYC1 = `SLCC_CNT_W'(`SLCC_VCO_C1),
    parameter slcc_pkg::slcc_cnt_t VCO_CYC2 = `SLCC_CNT_W'(`SLCC_VCO_C2),
    parameter slcc_pkg::slcc_cnt_t VCO_CYC3 = `SLCC_CNT_W'(`SLCC_VCO_C3),
    parameter slcc_pkg::slcc_cnt_t CL_CYC1  = `SLCC_CNT_W'(`SLCC_CL_C1),
    parameter slcc_pkg::slcc_cnt_t CL_CYC2  = `SLCC_CNT_W'(`SLCC_CL_C2),
    parameter slcc_pkg::slcc_cnt_t CL_CYC3  = `SLCC_CNT_W'(`SLCC_CL_C3)
) (
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   SYS_RST_I,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [`SLCC_ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [`SLCC_DAT_W-1:0] WB_DAT_I,
    output logic      [`SLCC_DAT_W-1:0] WB_DAT_O,
    output logic                        WB_ACK_O,
    output logic                        NARROW_BW_A_O,
    output logic                        PFD_STRETCH_B_O,
    output logic      [2:0]             LOOP_FILTER_ORDER_B_O,
    output logic                        CAL_BUSY_O,
    output logic                        VCO_SETTLE_O,
    output logic                        CL_SETTLE_O
);

    localparam slcc_pkg::slcc_cnt_t VCO_CYC0 = `SLCC_CNT_W'(`SLCC_VCO_C0);
    localparam slcc_pkg::slcc_cnt_t CL_CYC0  = `SLCC_CNT_W'(`SLCC_CL_C0);

    slcc_pkg::slcc_cfg_t   cfg;
    slcc_pkg::slcc_state_t state;
    slcc_pkg::slcc_state_t next_state;
    slcc_pkg::slcc_cnt_t   tmr_count;
    slcc_pkg::slcc_cnt_t   tmr_load_val;
    logic                  tmr_zero;
    logic                  tmr_load;
    logic                  ack;
    logic                  done;
    logic                  wb_req;
    logic                  wb_wr;
    logic                  lane0_wr;
    logic                  start_req;
    logic [`SLCC_REG_W-1:0] rd_byte;

    function automatic logic hit(input logic [`SLCC_ADR_W-1:0] adr,
                                 input logic [`SLCC_IDX_W-1:0] idx);
        hit = (adr[`SLCC_ADR_W-1:`SLCC_ADR_LSB] == idx) && (adr[`SLCC_ADR_LSB-1:0] == '0);
    endfunction : hit

    // Code to cycle count, minus one so the phase lasts exactly the count
    function automatic slcc_pkg::slcc_cnt_t sel_count(
        input logic [1:0]          code,
        input slcc_pkg::slcc_cnt_t c0,
        input slcc_pkg::slcc_cnt_t c1,
        input slcc_pkg::slcc_cnt_t c2,
        input slcc_pkg::slcc_cnt_t c3);
        slcc_pkg::slcc_cnt_t c;
        case (code)
            2'h0:    c = c0;
            2'h1:    c = c1;
            2'h2:    c = c2;
            default: c = c3;
        endcase
        sel_count = c - 1'b1;
    endfunction : sel_count

    // Bus slave: one wait state, ack drops the cycle after it was given
    assign wb_req   = WB_CYC_I && WB_STB_I;
    assign wb_wr    = wb_req && WB_WE_I && ack;
    assign lane0_wr = wb_wr && WB_SEL_I[0];

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ack <= 1'b0;
        end else begin
            ack <= wb_req && !ack;
        end
    end

    assign WB_ACK_O = ack;

    // Configuration fields; reserved positions are simply not stored
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg.narrow_bw_select_a <= `SLCC_RST_NBW; // R2
        end else if (lane0_wr && hit(WB_ADR_I, `SLCC_IDX_A_CAL1)) begin
            cfg.narrow_bw_select_a <= WB_DAT_I[`SLCC_NBW_BIT]; // R1
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg.pfd_pulse_stretch_b <= `SLCC_RST_STR; // R4
        end else if (lane0_wr && hit(WB_ADR_I, `SLCC_IDX_B_CTL2)) begin
            cfg.pfd_pulse_stretch_b <= WB_DAT_I[`SLCC_STR_BIT]; // R5
        end
    end

    // Reserved codes are stored as written; the analogue side sees them raw
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg.loop_filter_order_sel_b <= `SLCC_RST_FLT; // R6
        end else if (lane0_wr && hit(WB_ADR_I, `SLCC_IDX_B_CTL3)) begin
            cfg.loop_filter_order_sel_b <= WB_DAT_I[`SLCC_FLT_MSB:`SLCC_FLT_LSB]; // R7
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg.closed_loop_settle_sel_b <= `SLCC_RST_CLW; // R9
            cfg.vco_settle_sel_b         <= `SLCC_RST_VCW; // R13
        end else if (lane0_wr && hit(WB_ADR_I, `SLCC_IDX_B_CAL0)) begin
            cfg.closed_loop_settle_sel_b <= WB_DAT_I[`SLCC_CLW_MSB:`SLCC_CLW_LSB]; // R9
            cfg.vco_settle_sel_b         <= WB_DAT_I[`SLCC_VCW_MSB:`SLCC_VCW_LSB]; // R13
        end
    end

    assign NARROW_BW_A_O         = cfg.narrow_bw_select_a; // R1
    assign PFD_STRETCH_B_O       = cfg.pfd_pulse_stretch_b; // R4
    assign LOOP_FILTER_ORDER_B_O = cfg.loop_filter_order_sel_b; // R7

    // Start while busy is dropped rather than restarting a long wait
    assign start_req = lane0_wr && hit(WB_ADR_I, `SLCC_IDX_CAL_CMD)
                       && WB_DAT_I[`SLCC_START_BIT] && (state == slcc_pkg::SLCC_IDLE);

    // Settle sequencer: VCO wait, then closed-loop wait
    always_comb begin
        next_state   = state;
        tmr_load     = 1'b0;
        tmr_load_val = '0;
        case (state)
            slcc_pkg::SLCC_IDLE: begin
                if (start_req) begin
                    next_state   = slcc_pkg::SLCC_VCO_SETTLE;
                    tmr_load     = 1'b1;
                    tmr_load_val = sel_count(cfg.vco_settle_sel_b,
                                             VCO_CYC0, VCO_CYC1, VCO_CYC2, VCO_CYC3); // R13
                end
            end
            slcc_pkg::SLCC_VCO_SETTLE: begin
                if (tmr_zero) begin
                    next_state   = slcc_pkg::SLCC_CL_SETTLE;
                    tmr_load     = 1'b1;
                    tmr_load_val = sel_count(cfg.closed_loop_settle_sel_b,
                                             CL_CYC0, CL_CYC1, CL_CYC2, CL_CYC3); // R9
                end
            end
            slcc_pkg::SLCC_CL_SETTLE: begin
                if (tmr_zero) begin
                    next_state = slcc_pkg::SLCC_IDLE; // R16
                end
            end
            default: begin
                next_state = slcc_pkg::SLCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state <= slcc_pkg::SLCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Sticky done; a new start clears it, and the two cannot coincide
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            done <= 1'b0;
        end else if (state == slcc_pkg::SLCC_CL_SETTLE && tmr_zero) begin
            done <= 1'b1;
        end else if (start_req) begin
            done <= 1'b0;
        end
    end

    slcc_settle_timer u_timer (
        .clk_i      (SYS_CLK_I),
        .rst_i      (SYS_RST_I),
        .load_i     (tmr_load),
        .load_val_i (tmr_load_val),
        .count_o    (tmr_count),
        .zero_o     (tmr_zero)
    );

    // Phase flags taken from the next state, so pins come straight from flops
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            CAL_BUSY_O   <= 1'b0;
            VCO_SETTLE_O <= 1'b0;
            CL_SETTLE_O  <= 1'b0;
        end else begin
            CAL_BUSY_O   <= (next_state != slcc_pkg::SLCC_IDLE);
            VCO_SETTLE_O <= (next_state == slcc_pkg::SLCC_VCO_SETTLE);
            CL_SETTLE_O  <= (next_state == slcc_pkg::SLCC_CL_SETTLE);
        end
    end

    // Read mux; unmapped words and reserved bits read zero
    always_comb begin
        rd_byte = '0;
        if (hit(WB_ADR_I, `SLCC_IDX_A_CAL1)) begin
            rd_byte[`SLCC_NBW_BIT] = cfg.narrow_bw_select_a; // R15
        end else if (hit(WB_ADR_I, `SLCC_IDX_B_CTL2)) begin
            rd_byte[`SLCC_STR_BIT] = cfg.pfd_pulse_stretch_b; // R15
        end else if (hit(WB_ADR_I, `SLCC_IDX_B_CTL3)) begin
            rd_byte[`SLCC_FLT_MSB:`SLCC_FLT_LSB] = cfg.loop_filter_order_sel_b;
        end else if (hit(WB_ADR_I, `SLCC_IDX_B_CAL0)) begin
            rd_byte[`SLCC_CLW_MSB:`SLCC_CLW_LSB] = cfg.closed_loop_settle_sel_b;
            rd_byte[`SLCC_VCW_MSB:`SLCC_VCW_LSB] = cfg.vco_settle_sel_b;
        end else if (hit(WB_ADR_I, `SLCC_IDX_CAL_STS)) begin
            rd_byte[`SLCC_BUSY_BIT] = CAL_BUSY_O;
            rd_byte[`SLCC_VPH_BIT]  = VCO_SETTLE_O;
            rd_byte[`SLCC_CPH_BIT]  = CL_SETTLE_O;
            rd_byte[`SLCC_DONE_BIT] = done;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            WB_DAT_O <= '0;
        end else if (wb_req && !WB_WE_I && !ack) begin
            WB_DAT_O <= {{(`SLCC_DAT_W-`SLCC_REG_W){1'b0}}, rd_byte};
        end else begin
            WB_DAT_O <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    logic [`SLCC_CNT_W-1:0] phase_len;
    slcc_pkg::slcc_cnt_t    vco_expect;
    slcc_pkg::slcc_cnt_t    cl_expect;
    slcc_pkg::slcc_cnt_t    load_len;

    assign vco_expect = sel_count(cfg.vco_settle_sel_b,
                                  VCO_CYC0, VCO_CYC1, VCO_CYC2, VCO_CYC3);
    assign cl_expect  = sel_count(cfg.closed_loop_settle_sel_b,
                                  CL_CYC0, CL_CYC1, CL_CYC2, CL_CYC3);

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            phase_len <= '0;
            load_len  <= '0;
        end else if (tmr_load) begin
            phase_len <= '0;
            load_len  <= tmr_load_val;
        end else begin
            phase_len <= phase_len + 1'b1;
        end
    end

    chk_bw_write: assert property ( // R1
        lane0_wr && hit(WB_ADR_I, `SLCC_IDX_A_CAL1)
        |=> NARROW_BW_A_O == $past(WB_DAT_I[`SLCC_NBW_BIT]))
        else $error("narrow bandwidth select not taken from write");

    chk_bw_reset: assert property ( // R2
        $fell(SYS_RST_I) |-> !NARROW_BW_A_O && !PFD_STRETCH_B_O)
        else $error("bandwidth or stretch select not zero after reset");

    chk_stretch_write: assert property ( // R5
        lane0_wr && hit(WB_ADR_I, `SLCC_IDX_B_CTL2)
        |=> PFD_STRETCH_B_O == $past(WB_DAT_I[`SLCC_STR_BIT]))
        else $error("pulse stretch select not taken from write");

    chk_filter_reset: assert property ( // R6
        $fell(SYS_RST_I) |-> LOOP_FILTER_ORDER_B_O == `SLCC_RST_FLT)
        else $error("loop filter order not second order after reset");

    chk_filter_hold: assert property ( // R7
        !(lane0_wr && hit(WB_ADR_I, `SLCC_IDX_B_CTL3))
        |=> $stable(LOOP_FILTER_ORDER_B_O))
        else $error("loop filter order changed without a write");

    chk_reserved_zero: assert property ( // R15
        wb_req && !WB_WE_I && !ack && hit(WB_ADR_I, `SLCC_IDX_B_CTL2)
        |=> WB_ACK_O && WB_DAT_O[`SLCC_STR_BIT-1:0] == '0)
        else $error("reserved bits of stretch register read nonzero");

    chk_vco_load: assert property ( // R13
        start_req |=> VCO_SETTLE_O && tmr_count == $past(vco_expect))
        else $error("VCO wait not loaded from selected code");

    chk_cl_length: assert property ( // R14
        CL_SETTLE_O && tmr_zero |-> phase_len == load_len)
        else $error("closed loop wait length wrong");

    chk_cl_count: assert property ( // R16
        VCO_SETTLE_O && tmr_zero |=> CL_SETTLE_O && tmr_count == $past(cl_expect)
                                     ##1 (tmr_count == $past(cl_expect) - 1'b1 || !CL_SETTLE_O))
        else $error("closed loop counter not loaded or not counting");

    chk_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for more than one cycle");

    cov_start: cover property (start_req);
    cov_narrow: cover property (lane0_wr && WB_DAT_I[`SLCC_NBW_BIT]
                                && hit(WB_ADR_I, `SLCC_IDX_A_CAL1));
    cov_third: cover property (LOOP_FILTER_ORDER_B_O == `SLCC_FLT_THIRD);
    cov_done: cover property ($rose(done));

endmodule : slcc_regs

// file: sim/slcc_regs_tb.sv
// Self-checking bench for the synthesizer loop and calibration bank.
// Assumes src/ compiled first; the bench is the only Wishbone master.
`timescale 1ns/100ps
`include "slcc_defs.svh"

module slcc_regs_tb;
    // Short waits keep the run small; code 0 counts stay fixed in the design
    localparam int V1 = 20;
    localparam int V2 = 40;
    localparam int V3 = 60;
    localparam int C1 = 30;
    localparam int C2 = 50;
    localparam int C3 = 70;
    localparam int LIMIT = 20000;

    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic        nbw;
    logic        str;
    logic [2:0]  flt;
    logic        busy;
    logic        vph;
    logic        cph;
    logic [31:0] exp_q[$];
    int          failures;
    int          n_checks;
    int          cycles;
    int          vtab[4];
    int          ctab[4];
    logic [11:0] a_t[4];
    logic [7:0]  m_t[4];

    slcc_regs #(
        .VCO_CYC1(`SLCC_CNT_W'(V1)),
        .VCO_CYC2(`SLCC_CNT_W'(V2)),
        .VCO_CYC3(`SLCC_CNT_W'(V3)),
        .CL_CYC1 (`SLCC_CNT_W'(C1)),
        .CL_CYC2 (`SLCC_CNT_W'(C2)),
        .CL_CYC3 (`SLCC_CNT_W'(C3))
    ) dut (
        .SYS_CLK_I            (clk),
        .SYS_RST_I            (rst),
        .WB_CYC_I             (cyc),
        .WB_STB_I             (stb),
        .WB_WE_I              (we),
        .WB_ADR_I             (adr),
        .WB_SEL_I             (sel),
        .WB_DAT_I             (dat_w),
        .WB_DAT_O             (dat_r),
        .WB_ACK_O             (ack),
        .NARROW_BW_A_O        (nbw),
        .PFD_STRETCH_B_O      (str),
        .LOOP_FILTER_ORDER_B_O(flt),
        .CAL_BUSY_O           (busy),
        .VCO_SETTLE_O         (vph),
        .CL_SETTLE_O          (cph)
    );

    always #10 clk = ~clk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Request held until the edge at which ack is seen high
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= s;
        @(negedge clk);
        while (ack !== 1'b1) @(negedge clk);
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000, 4'h1);
    endtask : rd

    task automatic outs(input logic n, input logic s, input logic [2:0] f);
        @(negedge clk);
        cmp({31'h0, nbw}, {31'h0, n});
        cmp({31'h0, str}, {31'h0, s});
        cmp({29'h0, flt}, {29'h0, f});
    endtask : outs

    // Phase lengths seen at the ports, one sample per cycle
    task automatic meas(output int nv, output int nc);
        int g;
        nv = 0;
        nc = 0;
        g  = 0;
        @(negedge clk);
        while (vph !== 1'b1 && g < 10) begin
            g++;
            @(negedge clk);
        end
        while (vph === 1'b1) begin
            nv++;
            @(negedge clk);
        end
        while (cph === 1'b1) begin
            nc++;
            @(negedge clk);
        end
    endtask : meas

    task automatic cal(input int v, input int cl, input bit poke);
        int nv;
        int nc;
        wr(12'h214, {28'h0, 2'(cl), 2'(v)});
        wr(12'h218, 32'h0000_0001);
        fork
            meas(nv, nc);
            if (poke) begin
                // A second start mid-wait must not restart the count
                wr(12'h218, 32'h0000_0001);
                rd(12'h21c, 32'h0000_0003);
            end
        join
        cmp(32'(nv), 32'(vtab[v]));
        cmp(32'(nc), 32'(ctab[cl]));
        cmp({31'h0, busy}, 32'h0000_0000);
        rd(12'h21c, 32'h0000_0008);
    endtask : cal

    // Read results checked against the oldest note at each read ack
    always @(negedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
            cmp(dat_r, exp_q.size() > 0 ? exp_q.pop_front() : 32'hffff_ffff);
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        logic [31:0] d;
        clk      = 1'b0;
        rst      = 1'b1;
        cyc      = 1'b0;
        stb      = 1'b0;
        we       = 1'b0;
        adr      = 12'h000;
        sel      = 4'h0;
        dat_w    = 32'h0000_0000;
        failures = 0;
        n_checks = 0;
        cycles   = 0;
        vtab     = '{1000, V1, V2, V3};
        ctab     = '{1500, C1, C2, C3};
        a_t      = '{12'h1e0, 12'h20c, 12'h210, 12'h214};
        m_t      = '{8'h01, 8'h80, 8'h07, 8'h0f};
        d        = $urandom(32'h25fc);
        repeat (12) @(posedge clk);
        rst <= 1'b0;

        outs(1'b0, 1'b0, 3'h3);
        rd(12'h1e0, 32'h0000_0000);
        rd(12'h20c, 32'h0000_0000);
        rd(12'h210, 32'h0000_0003);
        rd(12'h214, 32'h0000_0001);
        $display("test reset_values done");

        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 3; k++) begin
                d = $urandom;
                if (i == 2) d[2:0] = d[2] ? 3'h7 : 3'h3;
                wr(a_t[i], d);
                rd(a_t[i], {24'h0, d[7:0] & m_t[i]});
            end
            wr(a_t[i], 32'h0000_00ff);
            rd(a_t[i], {24'h0, m_t[i]});
        end
        outs(1'b1, 1'b1, 3'h7);
        wb(1'b1, 12'h1e0, 32'h0000_0000, 4'he);
        rd(12'h1e0, 32'h0000_0001);
        wr(12'h200, 32'h0000_00ff);
        rd(12'h200, 32'h0000_0000);
        rd(12'h1e1, 32'h0000_0000);
        wr(12'h1e0, 32'h0000_0000);
        wr(12'h20c, 32'h0000_0000);
        wr(12'h210, 32'h0000_0003);
        outs(1'b0, 1'b0, 3'h3);
        $display("test field_access done");

        cal(0, 3, 1'b0);
        cal(1, 1, 1'b1);
        wr(12'h1e0, 32'h0000_0001);
        wr(12'h20c, 32'h0000_0080);
        wr(12'h210, 32'h0000_0007);
        outs(1'b1, 1'b1, 3'h7);
        cal(1, 3, 1'b0);
        cal(2, 0, 1'b0);
        cal(3, 2, 1'b0);
        $display("test settle_waits done");
        end_sim();
    end
endmodule : slcc_regs_tb
